// ==== shared/pmm_pkg.sv ====
// Constants for the position mode monitor
`default_nettype none

package pmm_pkg;

	// ----------------------------------------------------------------
	// Object indices
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_MODE_REQUEST      = 16'h6060;
	localparam logic [15:0] IDX_MODE_IN_EFFECT    = 16'h6061;
	localparam logic [15:0] IDX_DEMAND_POSITION   = 16'h6062;
	localparam logic [15:0] IDX_RAW_ENC_POSITION  = 16'h6063;
	localparam logic [15:0] IDX_ACTUAL_POSITION   = 16'h6064;
	localparam logic [15:0] IDX_LAG_ERROR_LIMIT   = 16'h6065;
	localparam logic [15:0] IDX_LAG_ERROR_TIMEOUT = 16'h6066;
	localparam logic [15:0] IDX_TARGET_WINDOW     = 16'h6067;
	localparam logic [15:0] IDX_TARGET_WIN_TIME   = 16'h6068;
	localparam logic [15:0] IDX_VELOCITY_SETPOINT = 16'h606B;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_MODE_REQUEST      = 8'h00;
	localparam logic [31:0] RST_LAG_ERROR_LIMIT   = 32'h0000_0100;
	localparam logic [15:0] RST_LAG_ERROR_TIMEOUT = 16'h0064;
	localparam logic [31:0] RST_TARGET_WINDOW     = 32'h0000_000A;
	localparam logic [15:0] RST_TARGET_WIN_TIME   = 16'h0064;
	localparam logic [31:0] RST_POSITION          = 32'h0000_0000;
	localparam logic [31:0] MONITOR_OFF           = 32'hFFFF_FFFF;

	// ----------------------------------------------------------------
	// Statusword bits and mode codes
	// ----------------------------------------------------------------
	localparam int STAT_BIT_TARGET = 10;
	localparam int STAT_BIT_LAG    = 13;
	localparam logic signed [7:0] MODE_MIN      = 8'shFE;
	localparam logic signed [7:0] MODE_MAX      = 8'sh0A;
	localparam logic signed [7:0] MODE_NONE     = 8'sh00;
	localparam logic signed [7:0] MODE_RESERVED = 8'sh05;
	localparam logic signed [7:0] MODE_PROF_POS = 8'sh01;
	localparam logic signed [7:0] MODE_INTP_POS = 8'sh07;
	localparam int MODE_COUNT = 13;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_PERIOD_NS  = 1000000;
	localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// ==== hdl/pmm_monitor.sv ====
// Mode selection and position supervision of the motor drive
`default_nettype none

module pmm_monitor #(
	parameter int MS_CYCLES = pmm_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// Object access port
	input  wire logic [15:0]        obj_index,
	input  wire logic               obj_write,
	input  wire logic               obj_read,
	input  wire logic [31:0]        obj_wdata,
	output logic      [31:0]        obj_rdata,
	output logic                    obj_ack,
	output logic                    obj_refused,
	// Drive side inputs
	input  wire logic               mode_change_ok,
	input  wire logic signed [31:0] demand_in,
	input  wire logic signed [31:0] target_pos,
	input  wire logic               fb_select,
	input  wire logic signed [31:0] enc_pos_a,
	input  wire logic signed [31:0] enc_pos_b,
	input  wire logic signed [31:0] user_pos_a,
	input  wire logic signed [31:0] user_pos_b,
	input  wire logic               homing_done,
	input  wire logic [31:0]        enc_resolution,
	input  wire logic               lag_reaction_en,
	input  wire logic signed [31:0] ramp_out,
	// Drive side outputs
	output logic signed [7:0]       mode_in_effect,
	output logic [12:0]             mode_onehot,
	output logic [15:0]             status_word,
	output logic                    error_entry,
	output logic                    raw_pos_valid,
	output logic signed [31:0]      vel_ctrl_setpoint
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// One-hot of mode codes -2..10; no change and reserved give zero
	function automatic logic [12:0] mode_decode(
		input logic signed [7:0] m
	);
		logic [12:0] oh;
		logic [7:0]  pos;
		oh  = 13'h0000;
		pos = 8'(m - pmm_pkg::MODE_MIN);
		if (m >= pmm_pkg::MODE_MIN && m <= pmm_pkg::MODE_MAX &&
			m != pmm_pkg::MODE_NONE && m != pmm_pkg::MODE_RESERVED) begin
			oh[pos[3:0]] = 1'b1;
		end
		return oh;
	endfunction

	// Magnitude of a signed difference, saturated to 32 bits
	function automatic logic [31:0] abs_diff(
		input logic signed [31:0] a,
		input logic signed [31:0] b
	);
		logic signed [32:0] d;
		logic [32:0]        mag;
		d   = 33'(a) - 33'(b);
		mag = d[32] ? 33'(-d) : 33'(d);
		return mag[32] ? 32'hFFFF_FFFF : mag[31:0];
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic signed [7:0]  mode_request;
	logic signed [31:0] demand_position;
	logic signed [31:0] raw_encoder_position;
	logic signed [31:0] actual_position;
	logic [31:0]        lag_error_limit;
	logic [15:0]        lag_error_timeout;
	logic [31:0]        target_window;
	logic [15:0]        target_window_time;
	logic signed [31:0] velocity_setpoint;
	logic signed [31:0] home_user_ofs;
	logic signed [31:0] home_dem_ofs;

	localparam int MS_W = $clog2(MS_CYCLES + 1);
	logic [MS_W-1:0] ms_cnt;
	logic            ms_tick;

	logic [16:0] tm_cnt [2];
	logic [1:0]  cond;
	logic [1:0]  flag;
	logic [1:0]  next_flag;
	logic [15:0] tm_limit [2];

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire logic [12:0] req_oh = mode_decode(mode_request);
	wire logic [12:0] eff_oh = mode_decode(mode_in_effect);
	wire logic take_mode = mode_change_ok && (|req_oh) &&
		(mode_request != mode_in_effect);
	wire logic pos_mode = (mode_in_effect == pmm_pkg::MODE_PROF_POS) ||
		(mode_in_effect == pmm_pkg::MODE_INTP_POS);

	wire logic signed [31:0] sel_enc  = fb_select ? enc_pos_b : enc_pos_a;
	wire logic signed [31:0] sel_user = fb_select ? user_pos_b : user_pos_a;

	wire logic lag_on = lag_error_limit != pmm_pkg::MONITOR_OFF;
	wire logic win_on = target_window != pmm_pkg::MONITOR_OFF;
	wire logic [31:0] lag_mag = abs_diff(actual_position, demand_position);
	wire logic [31:0] win_mag = abs_diff(actual_position, target_pos);

	assign cond[0] = lag_on && (lag_mag > lag_error_limit);
	assign cond[1] = win_on && pos_mode &&
		(win_mag < target_window);
	assign tm_limit[0] = lag_error_timeout;
	assign tm_limit[1] = target_window_time;

	wire logic hit_mode  = obj_index == pmm_pkg::IDX_MODE_REQUEST;
	wire logic hit_lag   = obj_index == pmm_pkg::IDX_LAG_ERROR_LIMIT;
	wire logic hit_lagto = obj_index == pmm_pkg::IDX_LAG_ERROR_TIMEOUT;
	wire logic hit_win   = obj_index == pmm_pkg::IDX_TARGET_WINDOW;
	wire logic hit_wint  = obj_index == pmm_pkg::IDX_TARGET_WIN_TIME;
	wire logic hit_rw = hit_mode || hit_lag || hit_lagto || hit_win ||
		hit_wint;
	wire logic hit_ro =
		obj_index == pmm_pkg::IDX_MODE_IN_EFFECT ||
		obj_index == pmm_pkg::IDX_DEMAND_POSITION ||
		obj_index == pmm_pkg::IDX_RAW_ENC_POSITION ||
		obj_index == pmm_pkg::IDX_ACTUAL_POSITION ||
		obj_index == pmm_pkg::IDX_VELOCITY_SETPOINT;
	wire logic wr_ok = obj_write && hit_rw;
	wire logic bad = (obj_write && !hit_rw) ||
		(obj_read && !obj_write && !hit_rw && !hit_ro);

	// Narrow objects read sign or zero extended to 32 bits
	wire logic [31:0] rd_mux =
		hit_mode  ? 32'(mode_request) :
		(obj_index == pmm_pkg::IDX_MODE_IN_EFFECT) ? 32'(mode_in_effect) :
		(obj_index == pmm_pkg::IDX_DEMAND_POSITION) ? demand_position :
		(obj_index == pmm_pkg::IDX_RAW_ENC_POSITION) ?
			raw_encoder_position :
		(obj_index == pmm_pkg::IDX_ACTUAL_POSITION) ? actual_position :
		hit_lag   ? lag_error_limit :
		hit_lagto ? {16'h0000, lag_error_timeout} :
		hit_win   ? target_window :
		hit_wint  ? {16'h0000, target_window_time} :
		(obj_index == pmm_pkg::IDX_VELOCITY_SETPOINT) ? velocity_setpoint :
		32'h0000_0000;

	// ----------------------------------------------------------------
	// Object access
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_request       <= pmm_pkg::RST_MODE_REQUEST;
			lag_error_limit    <= pmm_pkg::RST_LAG_ERROR_LIMIT;
			lag_error_timeout  <= pmm_pkg::RST_LAG_ERROR_TIMEOUT;
			target_window      <= pmm_pkg::RST_TARGET_WINDOW;
			target_window_time <= pmm_pkg::RST_TARGET_WIN_TIME;
		end else if (wr_ok) begin
			if (hit_mode)
				mode_request <= obj_wdata[7:0];
			if (hit_lag)
				lag_error_limit <= obj_wdata;
			if (hit_lagto)
				lag_error_timeout <= obj_wdata[15:0];
			if (hit_win)
				target_window <= obj_wdata;
			if (hit_wint)
				target_window_time <= obj_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			obj_rdata   <= 32'h0000_0000;
			obj_ack     <= 1'b0;
			obj_refused <= 1'b0;
		end else begin
			obj_ack     <= obj_read || obj_write;
			obj_refused <= bad;
			obj_rdata   <= obj_read ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Operating mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_in_effect <= pmm_pkg::MODE_NONE;
			mode_onehot    <= 13'h0000;
		end else begin
			if (take_mode)
				mode_in_effect <= mode_request;
			mode_onehot <= take_mode ? req_oh : eff_oh;
		end
	end

	// ----------------------------------------------------------------
	// Positions and velocity
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			home_user_ofs <= pmm_pkg::RST_POSITION;
			home_dem_ofs  <= pmm_pkg::RST_POSITION;
		end else if (homing_done) begin
			home_user_ofs <= sel_user;
			home_dem_ofs  <= demand_in;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			demand_position      <= pmm_pkg::RST_POSITION;
			actual_position      <= pmm_pkg::RST_POSITION;
			raw_encoder_position <= pmm_pkg::RST_POSITION;
			raw_pos_valid        <= 1'b0;
			velocity_setpoint    <= pmm_pkg::RST_POSITION;
			vel_ctrl_setpoint    <= pmm_pkg::RST_POSITION;
		end else begin
			demand_position <= homing_done ? pmm_pkg::RST_POSITION :
				demand_in - home_dem_ofs;
			actual_position <= homing_done ? pmm_pkg::RST_POSITION :
				sel_user - home_user_ofs;
			raw_encoder_position <= sel_enc;
			raw_pos_valid        <= enc_resolution != 32'h0000_0000;
			velocity_setpoint    <= ramp_out;
			vel_ctrl_setpoint    <= ramp_out;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond time base
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= ms_cnt == MS_W'(MS_CYCLES - 1);
			ms_cnt  <= (ms_cnt == MS_W'(MS_CYCLES - 1)) ? '0 :
				ms_cnt + MS_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Persistence timers, 0 = lag, 1 = target window
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_mon
		// Saturates one above the largest setting
		wire logic cnt_max = tm_cnt[i] == 17'h1_0000;
		assign next_flag[i] = cond[i] &&
			(tm_cnt[i] > {1'b0, tm_limit[i]});
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				tm_cnt[i] <= 17'h0_0000;
			end else if (!cond[i]) begin
				tm_cnt[i] <= 17'h0_0000;
			end else if (ms_tick && !cnt_max) begin
				tm_cnt[i] <= tm_cnt[i] + 17'h0_0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag        <= 2'b00;
			status_word <= 16'h0000;
			error_entry <= 1'b0;
		end else begin
			flag <= next_flag;
			status_word <= 16'h0000;
			status_word[pmm_pkg::STAT_BIT_LAG]    <= next_flag[0];
			status_word[pmm_pkg::STAT_BIT_TARGET] <= next_flag[1];
			error_entry <= next_flag[0] && !flag[0] &&
				lag_reaction_en;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_lag_off_clear: assert property (@(posedge clk) disable iff (!rst_b)
		lag_error_limit == pmm_pkg::MONITOR_OFF |=> !status_word[13])
		else $error("lag flag set while lag monitoring off");

	a_win_mode_gate: assert property (@(posedge clk) disable iff (!rst_b)
		!pos_mode |=> !status_word[10])
		else $error("target flag set outside position modes");

	a_win_off_clear: assert property (@(posedge clk) disable iff (!rst_b)
		target_window == pmm_pkg::MONITOR_OFF |=> !flag[1])
		else $error("target flag set while window monitoring off");

	a_lag_persist: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(flag[0]) |-> $past(tm_cnt[0]) > {1'b0, $past(lag_error_timeout)})
		else $error("lag flag rose before timeout elapsed");

	a_timer_restart: assert property (@(posedge clk) disable iff (!rst_b)
		!cond[0] ##1 !cond[0] |-> tm_cnt[0] == 17'h0_0000 && !flag[0])
		else $error("lag timer not restarted");

	a_err_entry: assert property (@(posedge clk) disable iff (!rst_b)
		error_entry |-> status_word[13] && !$past(status_word[13], 1))
		else $error("error entry without new lag flag");

	a_mode_adopt: assert property (@(posedge clk) disable iff (!rst_b)
		take_mode |=> mode_in_effect == $past(mode_request) && |mode_onehot)
		else $error("valid mode request not taken");

	a_mode_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(|req_oh) |=> mode_in_effect == $past(mode_in_effect))
		else $error("mode changed on invalid request");

	a_raw_valid: assert property (@(posedge clk) disable iff (!rst_b)
		enc_resolution == 32'h0000_0000 |=> !raw_pos_valid)
		else $error("raw position valid with zero resolution");

	a_raw_no_home: assert property (@(posedge clk) disable iff (!rst_b)
		homing_done |=> raw_encoder_position == $past(sel_enc) &&
			actual_position == 32'sh0000_0000)
		else $error("homing handled wrongly on positions");

	a_vel_follow: assert property (@(posedge clk) disable iff (!rst_b)
		##1 1'b1 |-> velocity_setpoint == $past(ramp_out) &&
			vel_ctrl_setpoint == velocity_setpoint)
		else $error("velocity setpoint not following ramp output");

	a_win_persist: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(flag[1]) |->
			$past(tm_cnt[1]) > {1'b0, $past(target_window_time)})
		else $error("target flag rose before window time elapsed");

	a_lag_clear: assert property (@(posedge clk) disable iff (!rst_b)
		!cond[0] |=> !status_word[13] && !error_entry)
		else $error("lag flag kept after deviation ended");

	a_win_restart: assert property (@(posedge clk) disable iff (!rst_b)
		!cond[1] |=> tm_cnt[1] == 17'h0_0000 && !status_word[10])
		else $error("window timer not restarted");

endmodule

`default_nettype wire

// ==== tb/pmm_ctrl_model.sv ====
// Fieldbus controller model driving the object access port
`default_nettype none

module pmm_ctrl_model (
	// Clock
	input  wire logic   clk,
	// Object access port
	output logic [15:0] obj_index,
	output logic        obj_write,
	output logic        obj_read,
	output logic [31:0] obj_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		obj_index = 16'h0000;
		obj_write = 1'b0;
		obj_read = 1'b0;
		obj_wdata = 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// One access: strobe for one cycle, then idle lines scrambled
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [15:0] i,
		input logic [31:0] d);
		@(negedge clk);
		obj_index = i;
		obj_wdata = d;
		obj_write = w;
		obj_read = !w;
		@(negedge clk);
		obj_write = 1'b0;
		obj_read = 1'b0;
		obj_index = ~i;
		obj_wdata = ~d;
	endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the position mode monitor
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk, rst_b, obj_write, obj_read, obj_ack;
	logic               obj_refused, mode_change_ok, fb_select;
	logic               homing_done, lag_reaction_en, error_entry;
	logic               raw_pos_valid;
	logic [15:0]        obj_index, status_word;
	logic [31:0]        obj_wdata, obj_rdata, enc_resolution;
	logic signed [31:0] demand_in, target_pos, enc_pos_a, enc_pos_b;
	logic signed [31:0] user_pos_a, user_pos_b, ramp_out;
	logic signed [31:0] vel_ctrl_setpoint;
	logic signed [7:0]  mode_in_effect, exp_m;
	logic [12:0]        mode_onehot;
	logic [32:0]        exq[$];
	logic [32:0]        got;
	int                 err_total, n_checks, n_entry, cyc;
	int                 seed = 32'hBAE9;

	pmm_monitor #(.MS_CYCLES(10)) i_pmm_monitor (.clk(clk), .rst_b(rst_b),
		.obj_index(obj_index), .obj_write(obj_write), .obj_read(obj_read),
		.obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
		.obj_refused(obj_refused), .mode_change_ok(mode_change_ok),
		.demand_in(demand_in), .target_pos(target_pos),
		.fb_select(fb_select), .enc_pos_a(enc_pos_a), .enc_pos_b(enc_pos_b),
		.user_pos_a(user_pos_a), .user_pos_b(user_pos_b),
		.homing_done(homing_done), .enc_resolution(enc_resolution),
		.lag_reaction_en(lag_reaction_en), .ramp_out(ramp_out),
		.mode_in_effect(mode_in_effect), .mode_onehot(mode_onehot),
		.status_word(status_word), .error_entry(error_entry),
		.raw_pos_valid(raw_pos_valid),
		.vel_ctrl_setpoint(vel_ctrl_setpoint));

	pmm_ctrl_model i_pmm_ctrl_model (.clk(clk), .obj_index(obj_index),
		.obj_write(obj_write), .obj_read(obj_read), .obj_wdata(obj_wdata));

	// ------------------------------------------------------------
	// Clock, timeout and output watchers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			conclude();
		end
	end

	// One count per history pulse, settled well before any check
	always @(posedge error_entry) n_entry++;

	always @(negedge clk) begin
		if (obj_ack === 1'b1) begin
			n_checks++;
			got = {obj_refused, obj_rdata};
			if (exq.size() == 0) begin
				$display("[ERR] %0t unexpected answer", $time);
				err_total++;
			end else if (got !== exq.pop_front()) begin
				$display("[ERR] %0t answer wrong %h", $time, got);
				err_total++;
			end
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic acc(input logic w, input logic [15:0] i,
		input logic [31:0] d, input logic [32:0] e);
		exq.push_back(e);
		i_pmm_ctrl_model.xfer(w, i, d);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("[ERR] %0t got %h expected %h", $time, g, e);
			err_total++;
		end
	endtask

	task automatic wait_st(input int b, input logic v, input int n);
		int k;
		k = 0;
		while (status_word[b] !== v && k < n) begin
			@(negedge clk);
			k++;
		end
		chk({31'h0, status_word[b]}, {31'h0, v});
	endtask

	task automatic hold_st(input int b, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(negedge clk);
			if (status_word[b] !== v) bad = 1'b1;
		end
		chk({31'h0, bad}, 32'h0);
	endtask

	task conclude;
		if (exq.size() != 0) err_total++;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_b, mode_change_ok, fb_select, homing_done} = 4'h0;
		{lag_reaction_en, demand_in, target_pos, ramp_out} = '0;
		{enc_pos_a, enc_pos_b, user_pos_a, user_pos_b} = '0;
		enc_resolution = 32'h0000_0400;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		acc(0, 16'h6060, 32'h0, 33'h0);
		acc(0, 16'h6061, 32'h0, 33'h0);
		acc(0, 16'h6065, 32'h0, 33'h0_0000_0100);
		acc(0, 16'h6066, 32'h0, 33'h0_0000_0064);
		acc(0, 16'h6067, 32'h0, 33'h0_0000_000A);
		acc(0, 16'h6068, 32'h0, 33'h0_0000_0064);
		acc(0, 16'h6062, 32'h0, 33'h0);
		acc(0, 16'h6069, 32'h0, 33'h1_0000_0000);
		acc(1, 16'h6061, 32'h3, 33'h1_0000_0000);
		acc(1, 16'h6062, 32'h5, 33'h1_0000_0000);
		// Every mode code, with no-change and reserved kept out
		mode_change_ok = 1'b1;
		exp_m = 8'sh00;
		for (int c = -2; c <= 10; c++) begin
			acc(1, 16'h6060, {24'h0, 8'(c)}, 33'h0);
			if (c != 0 && c != 5) exp_m = 8'(c);
			repeat (3) @(negedge clk);
			chk({24'h0, mode_in_effect}, {24'h0, exp_m});
			chk({19'h0, mode_onehot}, 32'h1 << 8'(exp_m + 8'sh02));
			acc(0, 16'h6061, 32'h0, {1'b0, {24{exp_m[7]}}, exp_m});
		end
		mode_change_ok = 1'b0;
		acc(1, 16'h6060, 32'h1, 33'h0);
		repeat (3) @(negedge clk);
		chk({24'h0, mode_in_effect}, 32'h0A);
		mode_change_ok = 1'b1;
		repeat (3) @(negedge clk);
		chk({24'h0, mode_in_effect}, 32'h01);
		// Position and velocity objects from both feedback sources
		for (int n = 0; n < 4; n++) begin
			demand_in = $random(seed);
			enc_pos_a = $random(seed);
			enc_pos_b = $random(seed);
			user_pos_a = $random(seed);
			user_pos_b = $random(seed);
			ramp_out = $random(seed);
			fb_select = 1'(n);
			repeat (2) @(negedge clk);
			acc(0, 16'h6062, 32'h0, {1'b0, demand_in});
			acc(0, 16'h6063, 32'h0,
				{1'b0, fb_select ? enc_pos_b : enc_pos_a});
			acc(0, 16'h6064, 32'h0,
				{1'b0, fb_select ? user_pos_b : user_pos_a});
			acc(0, 16'h606B, 32'h0, {1'b0, ramp_out});
			chk(vel_ctrl_setpoint, ramp_out);
		end
		// Following error: timeout 3 ms, limit 100
		{fb_select, demand_in, user_pos_a} = '0;
		lag_reaction_en = 1'b1;
		n_entry = 0;
		acc(1, 16'h6066, 32'h3, 33'h0);
		acc(1, 16'h6065, 32'd100, 33'h0);
		user_pos_a = 32'sd101;
		hold_st(13, 1'b0, 25);
		wait_st(13, 1'b1, 40);
		chk(32'(n_entry), 32'h1);
		user_pos_a = 32'sd100;
		wait_st(13, 1'b0, 3);
		hold_st(13, 1'b0, 80);
		lag_reaction_en = 1'b0;
		user_pos_a = -32'sd101;
		hold_st(13, 1'b0, 25);
		user_pos_a = 32'sd0;
		repeat (3) @(negedge clk);
		user_pos_a = -32'sd101;
		hold_st(13, 1'b0, 25);
		wait_st(13, 1'b1, 40);
		chk(32'(n_entry), 32'h1);
		acc(1, 16'h6065, 32'hFFFF_FFFF, 33'h0);
		wait_st(13, 1'b0, 4);
		hold_st(13, 1'b0, 80);
		// Target window: default 10, time 2 ms, mode 1
		acc(1, 16'h6068, 32'h2, 33'h0);
		target_pos = 32'sd1000;
		user_pos_a = 32'sd1009;
		hold_st(10, 1'b0, 15);
		wait_st(10, 1'b1, 40);
		user_pos_a = 32'sd1010;
		wait_st(10, 1'b0, 3);
		hold_st(10, 1'b0, 60);
		user_pos_a = 32'sd991;
		wait_st(10, 1'b1, 60);
		acc(1, 16'h6060, 32'h3, 33'h0);
		wait_st(10, 1'b0, 5);
		hold_st(10, 1'b0, 50);
		acc(1, 16'h6060, 32'h7, 33'h0);
		wait_st(10, 1'b1, 60);
		acc(1, 16'h6067, 32'hFFFF_FFFF, 33'h0);
		wait_st(10, 1'b0, 4);
		hold_st(10, 1'b0, 40);
		// Homing clears user units only; zero resolution flags raw
		homing_done = 1'b1;
		@(negedge clk);
		homing_done = 1'b0;
		repeat (2) @(negedge clk);
		acc(0, 16'h6064, 32'h0, 33'h0);
		acc(0, 16'h6063, 32'h0, {1'b0, enc_pos_a});
		enc_resolution = 32'h0;
		repeat (3) @(negedge clk);
		chk({31'h0, raw_pos_valid}, 32'h0);
		enc_resolution = 32'h0000_0400;
		repeat (3) @(negedge clk);
		chk({31'h0, raw_pos_valid}, 32'h1);
		repeat (3) @(negedge clk);
		conclude();
	end
endmodule

`default_nettype wire
